/* core/rtc_alarm_pkg.sv */
// Constants for the alarm register banks and the two index/data I/O port pairs.
// Assumes one 125 MHz core clock and an 8-bit host I/O bus.
package rtc_alarm_pkg;

    // I/O port offsets
    localparam logic [7:0] PORT_BANK0_INDEX = 8'h70;
    localparam logic [7:0] PORT_BANK0_DATA  = 8'h71;
    localparam logic [7:0] PORT_BANK1_INDEX = 8'h72;
    localparam logic [7:0] PORT_BANK1_DATA  = 8'h73;

    // Bank-0 indices
    localparam logic [7:0] IDX_CONTROL_REG_D       = 8'h0D;
    localparam logic [7:0] IDX_ALARM1_DAY_DEFAULT   = 8'h0E;
    localparam logic [7:0] IDX_ALARM1_MONTH_DEFAULT = 8'h0F;

    // Bank-1 indices
    localparam logic [7:0] IDX_ALARM2_SECONDS = 8'h00;
    localparam logic [7:0] IDX_ALARM2_MINUTES = 8'h01;
    localparam logic [7:0] IDX_ALARM2_HOURS   = 8'h02;
    localparam logic [7:0] IDX_ALARM2_DAY     = 8'h03;
    localparam logic [7:0] IDX_ALARM2_MONTH   = 8'h04;

    // Field positions
    localparam int SUPPLY_VALID_BIT = 7;
    localparam int PM_BIT           = 7;
    localparam int DONT_CARE_HI     = 7;
    localparam int DONT_CARE_LO     = 6;

    // Reset values
    localparam logic [7:0] RST_CONTROL_REG_D = 8'h00;
    localparam logic [7:0] RST_DAY_MONTH     = 8'hC0;
    localparam logic [7:0] RST_TIME          = 8'h00;
    localparam logic [7:0] RST_INDEX         = 8'h00;

    // Read value of an unmapped index
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

/* core/alarm_field_match.sv */
// Compares one alarm field with the matching current-time field.
// Assumes both bytes use the same encoding as chosen by the format bits.
`timescale 1ns/1ps
module alarm_field_match (
    input  wire logic [7:0] i_alarm,
    input  wire logic [7:0] i_time,
    input  wire logic       i_binary,
    input  wire logic       i_hour_field,
    input  wire logic       i_hour_24,
    output logic            o_match
);
    import rtc_alarm_pkg::*;

    logic dont_care;
    logic [7:0] alarm_norm;
    logic [7:0] time_norm;

    // Both top bits set means the field always matches
    assign dont_care = i_alarm[DONT_CARE_HI] & i_alarm[DONT_CARE_LO];

    // Bytes compared whole; in 12-hour mode the PM flag is part of the hours byte
    assign alarm_norm = i_alarm;
    assign time_norm  = i_time;

    // Equal under the active encoding; the byte images are unique per value
    assign o_match = dont_care | (alarm_norm == time_norm);

    // Encoding and hour mode do not change byte equality, kept for clarity
    logic unused_ok;
    assign unused_ok = i_binary ^ i_hour_field ^ i_hour_24;
endmodule

/* core/rtc_alarm_regs.sv */
// Alarm register banks, supply-validity status and index/data host ports.
// Assumes a synchronous 8-bit host I/O port; time counters live elsewhere.
`timescale 1ns/1ps
module rtc_alarm_regs (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    // Host I/O port
    input  wire logic [7:0] i_io_addr,
    input  wire logic       i_io_wr,
    input  wire logic       i_io_rd,
    input  wire logic [7:0] i_io_wdata,
    output logic [7:0]      o_io_rdata,
    output logic            o_io_hit,
    // Configuration and mode bits
    input  wire logic [7:0] i_alarm1_day_index,
    input  wire logic [7:0] i_alarm1_month_index,
    input  wire logic       i_number_format_select,
    input  wire logic       i_hour_format_select,
    input  wire logic       i_supply_ok_pin,
    // Current time from the counters
    input  wire logic [7:0] i_time_seconds,
    input  wire logic [7:0] i_time_minutes,
    input  wire logic [7:0] i_time_hours,
    input  wire logic [7:0] i_time_day,
    input  wire logic [7:0] i_time_month,
    // Alarm side
    input  wire logic       i_alarm1_time_match,
    input  wire logic       i_alarm1_ie_set,
    input  wire logic       i_alarm2_ie_set,
    input  wire logic       i_alarm_flags_read,
    output logic            o_supply_valid_flag,
    output logic            o_alarm1_date_match,
    output logic            o_alarm1_event,
    output logic            o_alarm2_event,
    output logic            o_alarm1_ie,
    output logic            o_alarm2_ie,
    output logic            o_alarm1_flag,
    output logic            o_alarm2_flag,
    output logic [7:0]      o_alarm1_day_field,
    output logic [7:0]      o_alarm1_month_field
);
    import rtc_alarm_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] bank0_index_reg;
    logic [7:0] bank1_index_reg;
    logic [7:0] alarm1_day_reg;
    logic [7:0] alarm1_month_reg;
    logic [7:0] alarm2_reg [5];
    logic       supply_meta_reg;
    logic       supply_valid_reg;
    logic       alarm1_ie_reg;
    logic       alarm2_ie_reg;
    logic       alarm1_flag_reg;
    logic       alarm2_flag_reg;
    logic       alarm2_hit_reg;
    logic       alarm1_hit_reg;
    logic [7:0] rdata_next;
    logic       hit_next;

    logic wr_bank0_data;
    logic wr_bank1_data;
    logic [4:0] field_match;
    logic [7:0] time_vec [5];
    logic       alarm2_all;
    logic       alarm1_date;

    assign wr_bank0_data = i_io_wr && (i_io_addr == PORT_BANK0_DATA);
    assign wr_bank1_data = i_io_wr && (i_io_addr == PORT_BANK1_DATA);

    // ------------------------------------------------------------
    // Supply validity, pin synchronised through two flops
    // ------------------------------------------------------------
    // Pin comes from the backup supply monitor, outside this clock
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            supply_meta_reg  <= 1'b0;
            supply_valid_reg <= RST_CONTROL_REG_D[SUPPLY_VALID_BIT];
        end else begin
            supply_meta_reg  <= i_supply_ok_pin;
            supply_valid_reg <= supply_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Index ports
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bank0_index_reg <= RST_INDEX;
            bank1_index_reg <= RST_INDEX;
        end else if (i_io_wr) begin
            if (i_io_addr == PORT_BANK0_INDEX) begin
                bank0_index_reg <= i_io_wdata;
            end
            if (i_io_addr == PORT_BANK1_INDEX) begin
                bank1_index_reg <= i_io_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Bank 0 alarm 1 date and month, at configured indices
    // ------------------------------------------------------------
    // Control register D has no write path; writes at its index drop unless an alarm 1 index aliases it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            alarm1_day_reg   <= RST_DAY_MONTH;
            alarm1_month_reg <= RST_DAY_MONTH;
        end else if (wr_bank0_data) begin
            if (bank0_index_reg == i_alarm1_day_index) begin
                alarm1_day_reg <= i_io_wdata;
            end
            if (bank0_index_reg == i_alarm1_month_index) begin
                alarm1_month_reg <= i_io_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Bank 1 alarm 2 fields, one per index 00h..04h
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_alarm2
            localparam logic [7:0] RST_VAL = (g >= 3) ? RST_DAY_MONTH : RST_TIME;
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    alarm2_reg[g] <= RST_VAL;
                end else if (wr_bank1_data && (bank1_index_reg == 8'(g))) begin
                    alarm2_reg[g] <= i_io_wdata;
                end
            end
            alarm_field_match u_match (
                .i_alarm      (alarm2_reg[g]),
                .i_time       (time_vec[g]),
                .i_binary     (i_number_format_select),
                .i_hour_field ((g == 2) ? 1'b1 : 1'b0),
                .i_hour_24    (i_hour_format_select),
                .o_match      (field_match[g])
            );
        end
    endgenerate

    // Current time fields in bank-1 index order
    assign time_vec[0] = i_time_seconds;
    assign time_vec[1] = i_time_minutes;
    assign time_vec[2] = i_time_hours;
    assign time_vec[3] = i_time_day;
    assign time_vec[4] = i_time_month;

    // Alarm 1 date part; its time part is matched by the clock core
    logic a1_day_ok;
    logic a1_mon_ok;
    alarm_field_match u_a1_day (
        .i_alarm      (alarm1_day_reg),
        .i_time       (i_time_day),
        .i_binary     (i_number_format_select),
        .i_hour_field (1'b0),
        .i_hour_24    (i_hour_format_select),
        .o_match      (a1_day_ok)
    );
    alarm_field_match u_a1_mon (
        .i_alarm      (alarm1_month_reg),
        .i_time       (i_time_month),
        .i_binary     (i_number_format_select),
        .i_hour_field (1'b0),
        .i_hour_24    (i_hour_format_select),
        .o_match      (a1_mon_ok)
    );

    assign alarm1_date = a1_day_ok & a1_mon_ok;
    assign alarm2_all  = &field_match;

    // ------------------------------------------------------------
    // Alarm events: one pulse on the rising edge of a full match
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            alarm2_hit_reg <= 1'b0;
            alarm1_hit_reg <= 1'b0;
        end else begin
            alarm2_hit_reg <= alarm2_all;
            alarm1_hit_reg <= alarm1_date & i_alarm1_time_match;
        end
    end

    assign o_alarm2_event = alarm2_all & ~alarm2_hit_reg;
    assign o_alarm1_event = alarm1_date & i_alarm1_time_match & ~alarm1_hit_reg;

    // ------------------------------------------------------------
    // Alarm enables and flags, held clear while supply is invalid
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !supply_valid_reg) begin
            alarm1_ie_reg <= 1'b0;
            alarm2_ie_reg <= 1'b0;
        end else begin
            if (i_alarm1_ie_set) begin
                alarm1_ie_reg <= 1'b1;
            end
            if (i_alarm2_ie_set) begin
                alarm2_ie_reg <= 1'b1;
            end
        end
    end

    // Set wins over a read clear in the same cycle,
    // so an alarm landing on the read cycle is not lost
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !supply_valid_reg) begin
            alarm1_flag_reg <= 1'b0;
            alarm2_flag_reg <= 1'b0;
        end else begin
            if (o_alarm1_event) begin
                alarm1_flag_reg <= 1'b1;
            end else if (i_alarm_flags_read) begin
                alarm1_flag_reg <= 1'b0;
            end
            if (o_alarm2_event) begin
                alarm2_flag_reg <= 1'b1;
            end else if (i_alarm_flags_read) begin
                alarm2_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Control register D wins if a configured alarm 1 index aliases it
    always_comb begin
        rdata_next = UNMAPPED_READ;
        hit_next   = 1'b1;
        case (i_io_addr)
            PORT_BANK0_INDEX: rdata_next = bank0_index_reg;
            PORT_BANK1_INDEX: rdata_next = bank1_index_reg;
            PORT_BANK0_DATA: begin
                if (bank0_index_reg == IDX_CONTROL_REG_D) begin
                    rdata_next = {supply_valid_reg, 7'h00};
                end else if (bank0_index_reg == i_alarm1_day_index) begin
                    rdata_next = alarm1_day_reg;
                end else if (bank0_index_reg == i_alarm1_month_index) begin
                    rdata_next = alarm1_month_reg;
                end else begin
                    hit_next = 1'b0;
                end
            end
            PORT_BANK1_DATA: begin
                if (bank1_index_reg <= IDX_ALARM2_MONTH) begin
                    rdata_next = alarm2_reg[bank1_index_reg[2:0]];
                end else begin
                    hit_next = 1'b0;
                end
            end
            default: hit_next = 1'b0;
        endcase
    end

    // Read data registered, valid the cycle after the read strobe
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_io_rdata <= 8'h00;
            o_io_hit   <= 1'b0;
        end else if (i_io_rd) begin
            o_io_rdata <= rdata_next;
            o_io_hit   <= hit_next;
        end
    end

    assign o_supply_valid_flag  = supply_valid_reg;
    assign o_alarm1_date_match  = alarm1_date;
    assign o_alarm1_ie          = alarm1_ie_reg;
    assign o_alarm2_ie          = alarm2_ie_reg;
    assign o_alarm1_flag        = alarm1_flag_reg;
    assign o_alarm2_flag        = alarm2_flag_reg;
    assign o_alarm1_day_field   = alarm1_day_reg;
    assign o_alarm1_month_field = alarm1_month_reg;
endmodule

/* test/rtc_alarm_regs_assertions.sv */
// Checker for the alarm register block: host port answers and alarm outputs.
// Assumes it is bound to rtc_alarm_regs and sees only that module's ports.
`timescale 1ns/1ps
module rtc_alarm_regs_checker (
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic [7:0] i_io_addr,
    input wire logic       i_io_wr,
    input wire logic       i_io_rd,
    input wire logic [7:0] o_io_rdata,
    input wire logic       o_io_hit,
    input wire logic       i_supply_ok_pin,
    input wire logic       i_alarm1_time_match,
    input wire logic       i_alarm1_ie_set,
    input wire logic       i_alarm_flags_read,
    input wire logic       o_supply_valid_flag,
    input wire logic       o_alarm1_date_match,
    input wire logic       o_alarm1_event,
    input wire logic       o_alarm2_event,
    input wire logic       o_alarm1_ie,
    input wire logic       o_alarm2_ie,
    input wire logic       o_alarm1_flag,
    input wire logic       o_alarm2_flag,
    input wire logic [7:0] o_alarm1_day_field
);
    import rtc_alarm_pkg::*;
    //--------------------------------------------------------------------
    // Properties
    //--------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    unmapped_read_a: assert property (
        i_io_rd && !(i_io_addr inside {[PORT_BANK0_INDEX:PORT_BANK1_DATA]})
        |=> o_io_rdata == UNMAPPED_READ && !o_io_hit) else $error("unmapped read answered");
    index_read_hit_a: assert property (
        i_io_rd && (i_io_addr == PORT_BANK0_INDEX || i_io_addr == PORT_BANK1_INDEX)
        |=> o_io_hit) else $error("index port read missed");
    read_data_hold_a: assert property (
        !i_io_rd |=> $stable(o_io_rdata) && $stable(o_io_hit)) else $error("read data moved");
    supply_sync_a: assert property (
        !$past(i_sys_rst) && !$past(i_sys_rst, 2)
        |-> o_supply_valid_flag == $past(i_supply_ok_pin, 2)) else $error("supply flag lag");
    supply_clears_a: assert property (
        !o_supply_valid_flag && !$past(o_supply_valid_flag)
        |-> !(o_alarm1_ie || o_alarm2_ie || o_alarm1_flag || o_alarm2_flag))
        else $error("enable or flag kept while invalid");
    enable_set_a: assert property (
        i_alarm1_ie_set && o_supply_valid_flag |=> o_alarm1_ie || !o_supply_valid_flag)
        else $error("enable not set");
    event_cause_a: assert property (
        o_alarm1_event |-> o_alarm1_date_match && i_alarm1_time_match)
        else $error("alarm 1 event without match");
    event_pulse_a: assert property (
        o_alarm2_event |=> !o_alarm2_event) else $error("alarm 2 event too long");
    flag_on_event_a: assert property (
        o_alarm2_event && o_supply_valid_flag |=> o_alarm2_flag)
        else $error("alarm 2 flag not set");
    flag_read_clear_a: assert property (
        i_alarm_flags_read && !o_alarm1_event |=> !o_alarm1_flag)
        else $error("alarm 1 flag not cleared");
    day_field_hold_a: assert property (
        !(i_io_wr && i_io_addr == PORT_BANK0_DATA) |=> $stable(o_alarm1_day_field))
        else $error("alarm 1 day changed without write");
endmodule

bind rtc_alarm_regs rtc_alarm_regs_checker chk_u (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata), .o_io_hit(o_io_hit),
    .i_supply_ok_pin(i_supply_ok_pin), .i_alarm1_time_match(i_alarm1_time_match),
    .i_alarm1_ie_set(i_alarm1_ie_set), .i_alarm_flags_read(i_alarm_flags_read),
    .o_supply_valid_flag(o_supply_valid_flag),
    .o_alarm1_date_match(o_alarm1_date_match), .o_alarm1_event(o_alarm1_event),
    .o_alarm2_event(o_alarm2_event), .o_alarm1_ie(o_alarm1_ie), .o_alarm2_ie(o_alarm2_ie),
    .o_alarm1_flag(o_alarm1_flag), .o_alarm2_flag(o_alarm2_flag),
    .o_alarm1_day_field(o_alarm1_day_field));

/* test/rtc_host_model.sv */
// Host processor model driving the index/data I/O ports.
// Assumes one-cycle strobes launched on falling edges of the core clock.
`timescale 1ns/1ps
module rtc_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_io_rdata,
    input  wire logic       i_io_hit,
    output logic [7:0]      o_io_addr,
    output logic            o_io_wr,
    output logic            o_io_rd,
    output logic [7:0]      o_io_wdata
);
    // Idle bus at time zero
    initial begin
        o_io_addr  = 8'h00;
        o_io_wr    = 1'b0;
        o_io_rd    = 1'b0;
        o_io_wdata = 8'h00;
    end
    // One write pulse; released lines show the inverse of the last value
    task automatic put(input logic [7:0] port, input logic [7:0] data);
        @(negedge i_core_clk);
        o_io_addr  = port;
        o_io_wdata = data;
        o_io_wr    = 1'b1;
        @(negedge i_core_clk);
        o_io_wr    = 1'b0;
        o_io_addr  = ~port;
        o_io_wdata = ~data;
    endtask
    // One read pulse; the answer is settled one edge later
    task automatic get(input logic [7:0] port, output logic [7:0] data, output logic hit);
        @(negedge i_core_clk);
        o_io_addr = port;
        o_io_rd   = 1'b1;
        @(negedge i_core_clk);
        o_io_rd   = 1'b0;
        o_io_addr = ~port;
        data      = i_io_rdata;
        hit       = i_io_hit;
    endtask
    // Index port first, then its paired data port
    task automatic wr_idx(input logic [7:0] iport, input logic [7:0] idx, input logic [7:0] data);
        put(iport, idx);
        put(iport + 8'h01, data);
    endtask
endmodule

/* test/rtc_alarm_regs_tb.sv */
// Self-checking bench for the alarm register block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module rtc_alarm_regs_tb;
    import rtc_alarm_pkg::*;
    typedef struct packed {
        logic [7:0] port;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
        logic       hit;
    } row_s;
    //--------------------------------------------------------------------
    // Signals and instances
    //--------------------------------------------------------------------
    logic       clk = 1'b0, rst = 1'b1, fmt = 1'b0, hfmt = 1'b0, sup = 1'b1, tm1 = 1'b0;
    logic       ie1s = 1'b0, ie2s = 1'b0, frd = 1'b0, wr, rd, hit, hv, svf, dm, ev1, ev2;
    logic       ie1, ie2, f1, f2;
    logic [7:0] addr, wd, rdata, rv, dayf, monf, didx = 8'h0E, midx = 8'h0F;
    logic [7:0] ts = 8'h00, tmin = 8'h00, th = 8'h00, tday = 8'h00, tmon = 8'h00;
    int         num_errors = 0, num_checks = 0;
    row_s       rows [10] = '{
        '{8'h72, 8'h00, 8'h59, 8'h59, 1'b1}, '{8'h72, 8'h01, 8'h3B, 8'h3B, 1'b1},
        '{8'h72, 8'h02, 8'h17, 8'h17, 1'b1}, '{8'h72, 8'h02, 8'h92, 8'h92, 1'b1},
        '{8'h72, 8'h03, 8'h31, 8'h31, 1'b1}, '{8'h72, 8'h04, 8'h0C, 8'h0C, 1'b1},
        '{8'h72, 8'h05, 8'hAA, 8'h00, 1'b0}, '{8'h70, 8'h0E, 8'h1F, 8'h1F, 1'b1},
        '{8'h70, 8'h0F, 8'h12, 8'h12, 1'b1}, '{8'h70, 8'h0D, 8'h7F, 8'h80, 1'b1}};
    always #4 clk = ~clk;
    rtc_host_model host_u (.i_core_clk(clk), .i_io_rdata(rdata), .i_io_hit(hit),
        .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wd));
    rtc_alarm_regs dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_io_addr(addr), .i_io_wr(wr),
        .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdata), .o_io_hit(hit),
        .i_alarm1_day_index(didx), .i_alarm1_month_index(midx),
        .i_number_format_select(fmt), .i_hour_format_select(hfmt), .i_supply_ok_pin(sup),
        .i_time_seconds(ts), .i_time_minutes(tmin), .i_time_hours(th), .i_time_day(tday),
        .i_time_month(tmon), .i_alarm1_time_match(tm1), .i_alarm1_ie_set(ie1s),
        .i_alarm2_ie_set(ie2s), .i_alarm_flags_read(frd), .o_supply_valid_flag(svf),
        .o_alarm1_date_match(dm), .o_alarm1_event(ev1), .o_alarm2_event(ev2),
        .o_alarm1_ie(ie1), .o_alarm2_ie(ie2), .o_alarm1_flag(f1), .o_alarm2_flag(f2),
        .o_alarm1_day_field(dayf), .o_alarm1_month_field(monf));
    //--------------------------------------------------------------------
    // Checking and closing
    //--------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Pulses one alarm-side strobe for one cycle
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // Watchdog
    initial begin
        #100us;
        num_errors++;
        wrap_up();
    end
    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            fmt  = i[0];
            hfmt = i[1];
            host_u.wr_idx(rows[i].port, rows[i].idx, rows[i].wd);
            host_u.get(rows[i].port + 8'h01, rv, hv);
            if (rows[i].port == PORT_BANK1_INDEX) begin
                check("bank 1 data", rv, rows[i].exp);
            end else begin
                check("bank 0 data", rv, rows[i].exp);
            end
            check("data hit", 8'(hv), 8'(rows[i].hit));
            host_u.get(rows[i].port, rv, hv);
            check("index readback", rv, rows[i].idx);
        end
        host_u.get(8'h74, rv, hv);
        check("unmapped data", rv, UNMAPPED_READ);
        check("unmapped hit", 8'(hv), 8'h00);
        check("day field", dayf, 8'h1F);
        check("month field", monf, 8'h12);
        didx = 8'h20;
        midx = 8'h21;
        host_u.wr_idx(PORT_BANK0_INDEX, 8'h20, 8'h05);
        check("moved day field", dayf, 8'h05);
        host_u.wr_idx(PORT_BANK0_INDEX, 8'h21, 8'h11);
        check("moved month field", monf, 8'h11);
        host_u.wr_idx(PORT_BANK0_INDEX, 8'h0E, 8'h09);
        host_u.get(PORT_BANK0_DATA, rv, hv);
        check("old day index", rv, UNMAPPED_READ);
        check("old day hit", 8'(hv), 8'h00);
        tday = 8'h06;
        tmon = 8'h11;
        #1 check("date mismatch", 8'(dm), 8'h00);
        host_u.wr_idx(PORT_BANK0_INDEX, 8'h20, RST_DAY_MONTH);
        #1 check("day dont care", 8'(dm), 8'h01);
        @(negedge clk) {ts, tmin, th, tday} = {8'h59, 8'h3B, 8'h92, 8'h31};
        pulse(ie1s);
        pulse(ie2s);
        check("enable 1", 8'(ie1), 8'h01);
        check("enable 2", 8'(ie2), 8'h01);
        @(negedge clk) tm1 = 1'b1;
        #1 check("alarm 1 event", 8'(ev1), 8'h01);
        repeat (3) @(negedge clk);
        check("alarm 1 flag", 8'(f1), 8'h01);
        tmon = 8'h0C;
        #1 check("alarm 2 event", 8'(ev2), 8'h01);
        repeat (3) @(negedge clk);
        check("alarm 2 flag", 8'(f2), 8'h01);
        pulse(frd);
        check("flags cleared", 8'({f1, f2}), 8'h00);
        ts = 8'h58;
        @(negedge clk) ts = 8'h59;
        @(negedge clk) check("alarm 2 again", 8'(f2), 8'h01);
        sup = 1'b0;
        repeat (3) @(negedge clk);
        pulse(ie2s);
        check("supply flag", 8'(svf), 8'h00);
        check("enables held", 8'({ie1, ie2}), 8'h00);
        check("flags held", 8'({f1, f2}), 8'h00);
        host_u.wr_idx(PORT_BANK0_INDEX, IDX_CONTROL_REG_D, 8'hFF);
        host_u.get(PORT_BANK0_DATA, rv, hv);
        check("invalid status", rv, RST_CONTROL_REG_D);
        @(negedge clk) rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check("day reset", dayf, RST_DAY_MONTH);
        check("month reset", monf, RST_DAY_MONTH);
        for (int i = 0; i < 5; i++) begin
            host_u.put(PORT_BANK1_INDEX, 8'(i));
            host_u.get(PORT_BANK1_DATA, rv, hv);
            if (i < 3) begin
                check("alarm 2 time reset", rv, RST_TIME);
            end else begin
                check("alarm 2 date reset", rv, RST_DAY_MONTH);
            end
        end
        wrap_up();
    end
endmodule
